// [hw/ledsc_pkg.sv]
// Constants and types for the LED sequencer control register bank
package ledsc_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_ENABLE  = 8'h00;
	localparam logic [7:0] ADDR_OPMODE  = 8'h01;
	localparam logic [7:0] ADDR_DUTY0   = 8'h02;
	localparam logic [7:0] ADDR_LEVEL0  = 8'h05;
	localparam logic [7:0] ADDR_PC0     = 8'h09;
	localparam int         NUM_CH       = 3;
	// Enable register fields
	localparam int         LOG_BIT      = 7;
	localparam int         CHIP_BIT     = 6;
	// Channel 0 (red) sits highest: field base = 2*(2-ch)
	localparam int         RED_FIELD_LO = 4;
	// Reset values
	localparam logic [7:0] ENABLE_RST   = 8'h00;
	localparam logic [7:0] OPMODE_RST   = 8'h00;
	localparam logic [7:0] DUTY_RST     = 8'h00;
	localparam logic [7:0] LEVEL_RST    = 8'hAF;
	localparam logic [3:0] PC_RST       = 4'h0;
	// Timing
	localparam int         CLK_KHZ      = 25000;
	localparam int         STARTUP_US   = 500;
	localparam int         STARTUP_CYC  = (STARTUP_US * CLK_KHZ + 999) / 1000;

	typedef enum logic [1:0] {
		EXEC_HOLD = 2'h0,
		EXEC_STEP = 2'h1,
		EXEC_RUN  = 2'h2,
		EXEC_ONCE = 2'h3
	} ledsc_exec_t;

	typedef enum logic [1:0] {
		MODE_OFF    = 2'h0,
		MODE_LOAD   = 2'h1,
		MODE_RUN    = 2'h2,
		MODE_DIRECT = 2'h3
	} ledsc_mode_t;

	typedef struct packed {
		logic       enabled;
		logic       loadOpen;
		logic       runLevel;
		logic       issue;
		logic       direct;
		logic [7:0] duty;
		logic [7:0] level;
		logic [3:0] pc;
	} ledsc_chan_t;
endpackage

// [hw/ledsc_regs.sv]
// Control register bank of a three-channel LED sequencer
// Contract
// - Enable bit 7 turns on logarithmic dimming
// - Chip enable bit 6 starts 500 us startup
// - Enable pin low clears chip enable
// - Two-bit run control per channel, read/write
// - Hold: finish current instruction, then stop
// - Program counter accessible only while holding
// - Step: run one, increment counter, back to hold
// - Run: execute continuously from current counter
// - Once: run one, no increment, back to hold
// - Run control taken on 32 kHz ticks
// - Per-channel mode; zero disables channel
// - Load mode opens memory, clears counter
// - Run mode executes per run control
// - Direct mode drives PWM from duty register
// - Mode fields taken on 32 kHz ticks
// - Drive level linear, 0.1 mA per code
// - Drive level resets to 0xAF
`timescale 1ns/1ps
module ledsc_regs #(
	parameter int STARTUP_CYCLES = ledsc_pkg::STARTUP_CYC
) (
	input  wire logic                                mclk,
	input  wire logic                                rst,
	input  wire logic                                enPin,
	input  wire logic                                slowClkPin,
	input  wire logic [7:0]                          regAddr,
	input  wire logic [7:0]                          regWdata,
	input  wire logic                                regWr,
	input  wire logic                                regRd,
	output logic      [7:0]                          regRdata,
	input  wire logic [ledsc_pkg::NUM_CH-1:0]        instrBusy,
	input  wire logic [ledsc_pkg::NUM_CH-1:0]        instrDone,
	input  wire logic [ledsc_pkg::NUM_CH-1:0]        pcAdvance,
	input  wire logic [ledsc_pkg::NUM_CH-1:0][7:0]   progDuty,
	output logic                                     logDimming,
	output logic                                     chipReady,
	output ledsc_pkg::ledsc_chan_t [ledsc_pkg::NUM_CH-1:0] chanOut
);
	initial begin
		if (STARTUP_CYCLES < 1 || STARTUP_CYCLES > 1048575) begin
			$error("STARTUP_CYCLES out of range");
		end
		// Field packing of the enable and mode registers is fixed at three channels
		if (ledsc_pkg::NUM_CH != 3) begin
			$error("NUM_CH must be 3");
		end
	end

	localparam int N = ledsc_pkg::NUM_CH;

	logic [7:0]        enable_ff;
	logic [7:0]        opmode_ff;
	logic [N-1:0][7:0] duty_ff;
	logic [N-1:0][7:0] level_ff;
	logic [N-1:0][3:0] pc_ff;
	logic [N-1:0]      clrExec;
	logic [N-1:0][1:0] execSh_ff;
	logic [N-1:0][1:0] modeSh_ff;
	logic [1:0]        enSync_ff;
	logic [2:0]        slowSync_ff;
	logic              tick;
	logic [19:0]       startCnt_ff;
	logic              chipReady_ff;
	logic [7:0]        regRdata_ff;

	// Pins cross into mclk through two flops before use
	always_ff @(posedge mclk) begin
		if (rst) begin
			enSync_ff <= 2'h0;
		end else begin
			enSync_ff <= {enSync_ff[0], enPin};
		end
	end

	// Third flop only delays the synchronised copy to find the rising edge
	always_ff @(posedge mclk) begin
		if (rst) begin
			slowSync_ff <= 3'h0;
		end else begin
			slowSync_ff <= {slowSync_ff[1:0], slowClkPin};
		end
	end

	// Rising edge of the slow clock, seen on the synchronised copies only
	assign tick = slowSync_ff[1] & ~slowSync_ff[2];

	// Enable register: host writes, pin clear and engine clears of run control
	always_ff @(posedge mclk) begin
		if (rst) begin
			enable_ff <= ledsc_pkg::ENABLE_RST;
		end else begin
			for (int c = 0; c < N; c++) begin
				if (clrExec[c]) begin
					enable_ff[ledsc_pkg::RED_FIELD_LO-2*c +: 2] <= 2'h0;
				end
			end
			// A host write overrides a same-cycle engine clear: it is the newer intent
			if (regWr && regAddr == ledsc_pkg::ADDR_ENABLE) begin
				enable_ff <= regWdata;
			end
			if (!enSync_ff[1]) begin
				enable_ff[ledsc_pkg::CHIP_BIT] <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			opmode_ff <= ledsc_pkg::OPMODE_RST;
		end else if (regWr && regAddr == ledsc_pkg::ADDR_OPMODE) begin
			opmode_ff <= {2'h0, regWdata[5:0]};
		end
	end

	// Startup delay counts from the set of chip enable
	always_ff @(posedge mclk) begin
		if (rst || !enable_ff[ledsc_pkg::CHIP_BIT]) begin
			startCnt_ff  <= 20'h0;
			chipReady_ff <= 1'b0;
		end else if (startCnt_ff == 20'(STARTUP_CYCLES - 1)) begin
			chipReady_ff <= 1'b1;
		end else begin
			startCnt_ff <= startCnt_ff + 20'h1;
		end
	end

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : gCh
			localparam int LO = ledsc_pkg::RED_FIELD_LO - 2 * g;
			logic       pend_ff;
			logic       incr_ff;
			logic [1:0] hostExec;
			assign hostExec = enable_ff[LO +: 2];

			always_ff @(posedge mclk) begin
				if (rst) begin
					duty_ff[g] <= ledsc_pkg::DUTY_RST;
				end else if (regWr && regAddr == ledsc_pkg::ADDR_DUTY0 + 8'(g)) begin
					duty_ff[g] <= regWdata;
				end
			end

			always_ff @(posedge mclk) begin
				if (rst) begin
					level_ff[g] <= ledsc_pkg::LEVEL_RST;
				end else if (regWr && regAddr == ledsc_pkg::ADDR_LEVEL0 + 8'(g)) begin
					level_ff[g] <= regWdata;
				end
			end

			// Fields reach the engine side only on slow clock ticks
			always_ff @(posedge mclk) begin
				if (rst) begin
					execSh_ff[g] <= 2'h0;
				end else if (clrExec[g]) begin
					execSh_ff[g] <= 2'h0;
				end else if (tick) begin
					execSh_ff[g] <= hostExec;
				end
			end

			// Mode is never cleared by the engine, only re-copied on ticks
			always_ff @(posedge mclk) begin
				if (rst) begin
					modeSh_ff[g] <= 2'h0;
				end else if (tick) begin
					modeSh_ff[g] <= opmode_ff[LO +: 2];
				end
			end

			// Single instruction request: step or once, answered by instrDone
			always_ff @(posedge mclk) begin
				if (rst) begin
					pend_ff <= 1'b0;
					incr_ff <= 1'b0;
				end else if (pend_ff) begin
					if (instrDone[g]) begin
						pend_ff <= 1'b0;
					end
				end else if (tick && !instrBusy[g]
					&& modeSh_ff[g] == ledsc_pkg::MODE_RUN
					&& (execSh_ff[g] == ledsc_pkg::EXEC_STEP
					|| execSh_ff[g] == ledsc_pkg::EXEC_ONCE)) begin
					pend_ff <= 1'b1;
					incr_ff <= (execSh_ff[g] == ledsc_pkg::EXEC_STEP);
				end
			end
			assign clrExec[g] = pend_ff & instrDone[g];

			// Counter: load clear, then engine advance, then host write in hold
			always_ff @(posedge mclk) begin
				if (rst) begin
					pc_ff[g] <= ledsc_pkg::PC_RST;
				end else if (modeSh_ff[g] == ledsc_pkg::MODE_LOAD) begin
					pc_ff[g] <= ledsc_pkg::PC_RST;
				end else if ((clrExec[g] && incr_ff)
					|| (pcAdvance[g] && execSh_ff[g] == ledsc_pkg::EXEC_RUN)) begin
					pc_ff[g] <= pc_ff[g] + 4'h1;
				end else if (regWr && regAddr == ledsc_pkg::ADDR_PC0 + 8'(g)
					&& hostExec == ledsc_pkg::EXEC_HOLD) begin
					pc_ff[g] <= regWdata[3:0];
				end
			end

			always_ff @(posedge mclk) begin
				if (rst) begin
					chanOut[g].enabled  <= 1'b0;
					chanOut[g].loadOpen <= 1'b0;
					chanOut[g].direct   <= 1'b0;
				end else begin
					chanOut[g].enabled  <= chipReady_ff
						&& modeSh_ff[g] != ledsc_pkg::MODE_OFF;
					chanOut[g].loadOpen <= modeSh_ff[g] == ledsc_pkg::MODE_LOAD;
					chanOut[g].direct   <= modeSh_ff[g] == ledsc_pkg::MODE_DIRECT;
				end
			end

			always_ff @(posedge mclk) begin
				if (rst) begin
					chanOut[g].runLevel <= 1'b0;
					chanOut[g].issue    <= 1'b0;
				end else begin
					// Dropping this level lets the engine end its instruction and stop
					chanOut[g].runLevel <= chipReady_ff
						&& modeSh_ff[g] == ledsc_pkg::MODE_RUN
						&& execSh_ff[g] == ledsc_pkg::EXEC_RUN;
					chanOut[g].issue    <= tick && !pend_ff && !instrBusy[g]
						&& modeSh_ff[g] == ledsc_pkg::MODE_RUN
						&& (execSh_ff[g] == ledsc_pkg::EXEC_STEP
						|| execSh_ff[g] == ledsc_pkg::EXEC_ONCE);
				end
			end

			// Data fields of the channel word
			always_ff @(posedge mclk) begin
				if (rst) begin
					chanOut[g].duty     <= 8'h00;
					chanOut[g].level    <= 8'h00;
					chanOut[g].pc       <= 4'h0;
				end else begin
					chanOut[g].duty     <= (modeSh_ff[g] == ledsc_pkg::MODE_DIRECT)
						? duty_ff[g] : progDuty[g];
					chanOut[g].level    <= level_ff[g];
					chanOut[g].pc       <= pc_ff[g];
				end
			end
		end
	endgenerate

	// Read path; counter reads as zero outside hold, unmapped reads as zero
	always_ff @(posedge mclk) begin
		if (rst) begin
			regRdata_ff <= 8'h00;
		end else if (regRd) begin
			regRdata_ff <= 8'h00;
			if (regAddr == ledsc_pkg::ADDR_ENABLE) begin
				regRdata_ff <= enable_ff;
			end
			if (regAddr == ledsc_pkg::ADDR_OPMODE) begin
				regRdata_ff <= opmode_ff;
			end
			for (int c = 0; c < N; c++) begin
				if (regAddr == ledsc_pkg::ADDR_DUTY0 + 8'(c)) begin
					regRdata_ff <= duty_ff[c];
				end
				if (regAddr == ledsc_pkg::ADDR_LEVEL0 + 8'(c)) begin
					regRdata_ff <= level_ff[c];
				end
				if (regAddr == ledsc_pkg::ADDR_PC0 + 8'(c)
					&& enable_ff[ledsc_pkg::RED_FIELD_LO-2*c +: 2] == 2'h0) begin
					regRdata_ff <= {4'h0, pc_ff[c]};
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			logDimming <= 1'b0;
		end else begin
			logDimming <= enable_ff[ledsc_pkg::LOG_BIT];
		end
	end

	// Extra stage keeps every top output straight from a flop
	always_ff @(posedge mclk) begin
		if (rst) begin
			chipReady <= 1'b0;
		end else begin
			chipReady <= chipReady_ff;
		end
	end

	assign regRdata = regRdata_ff;
endmodule // ledsc_regs

// [verification/ledsc_engine_model.sv]
// Program engine model on the far side of the channel outputs
`timescale 1ns/1ps
module ledsc_engine_model (
	input wire logic                         mclk,
	input wire logic                         rst,
	input wire ledsc_pkg::ledsc_chan_t [2:0] chanOut,
	output logic [2:0]                       instrBusy,
	output logic [2:0]                       instrDone,
	output logic [2:0]                       pcAdvance,
	output logic [2:0][7:0]                  progDuty
);
	logic [2:0][1:0] cnt_ff;
	// Four cycles per instruction, so hold must wait out a busy engine
	always_ff @(posedge mclk) begin
		for (int i = 0; i < 3; i++) begin
			instrDone[i] <= !rst && instrBusy[i] && cnt_ff[i] == 2'h3;
			pcAdvance[i] <= !rst && chanOut[i].runLevel && progDuty[i][2:0] == 3'h7;
			// Duty changes every cycle so a stale copy never looks right
			progDuty[i] <= rst ? 8'h00 : progDuty[i] + 8'(i + 1);
			cnt_ff[i] <= (rst || chanOut[i].issue) ? 2'h0 : cnt_ff[i] + 2'h1;
			if (rst || cnt_ff[i] == 2'h3)
				instrBusy[i] <= 1'b0;
			if (!rst && chanOut[i].issue)
				instrBusy[i] <= 1'b1;
		end
	end
endmodule // ledsc_engine_model

// [verification/ledsc_regs_assertions.sv]
// Port assertions for the LED sequencer register bank
`timescale 1ns/1ps
module ledsc_regs_assertions #(
	parameter int STARTUP_CYCLES = 20
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic enPin,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regRdata,
	input wire logic [ledsc_pkg::NUM_CH-1:0][7:0] progDuty,
	input wire logic logDimming,
	input wire logic chipReady,
	input wire ledsc_pkg::ledsc_chan_t [ledsc_pkg::NUM_CH-1:0] chanOut
);
	localparam int RDY_HI = STARTUP_CYCLES + 4;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	chk_log_follow: assert property (regWr && regAddr == 8'h00
		|-> ##2 logDimming == $past(regWdata[7], 2)) else $error("log bit wrong");
	chk_pin_clear: assert property (!enPin [*5] |=> !chipReady)
		else $error("ready with pin low");
	chk_ready_delay: assert property (regWr && regAddr == 8'h00 && regWdata[6] && !chipReady
		|=> !chipReady [*8] ##[1:RDY_HI] chipReady) else $error("startup time wrong");
	chk_read_level: assert property (regRd && !regWr && regAddr == 8'h05
		|=> regRdata == chanOut[0].level) else $error("level read wrong");
	chk_level_write: assert property (regWr && regAddr == 8'h06
		|-> ##2 chanOut[1].level == $past(regWdata, 2)) else $error("level write lost");
	chk_mode_top: assert property (regRd && regAddr == 8'h01
		|=> regRdata[7:6] == 2'h0) else $error("mode top bits set");
	chk_duty_prog: assert property (!$past(rst) && !chanOut[0].direct
		&& !$past(chanOut[0].direct) |-> chanOut[0].duty == $past(progDuty[0]))
		else $error("program duty lost");
	chk_level_reset: assert property ($past(rst) |=> chanOut[2].level == 8'hAF)
		else $error("level reset wrong");
	cover property (chanOut[0].issue);
	cover property ($rose(chipReady));
	cover property (chanOut[2].runLevel);
endmodule // ledsc_regs_assertions

bind ledsc_regs ledsc_regs_assertions #(.STARTUP_CYCLES(STARTUP_CYCLES)) uChk (.*);

// [verification/led_sequencer_control_regs_tb_top.sv]
// Self-checking bench for the LED sequencer register bank
`timescale 1ns/1ps
module led_sequencer_control_regs_tb_top;
	logic mclk = 1'b0, rst = 1'b1, enPin = 1'b1, slowClkPin = 1'b0;
	logic regWr = 1'b0, regRd = 1'b0, rdPend = 1'b0, logDimming, chipReady;
	logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, v, dB;
	logic [2:0] instrBusy, instrDone, pcAdvance;
	logic [2:0][7:0] progDuty;
	ledsc_pkg::ledsc_chan_t [2:0] chanOut;
	logic [7:0] expQ[$];
	int n_mismatch = 0, n_compared = 0;
	always #20 mclk = ~mclk;
	// Slow pin period drifts against mclk, so tick phase varies
	always #15625 slowClkPin = ~slowClkPin;
	ledsc_regs #(.STARTUP_CYCLES(20)) DUT (.*);
	ledsc_engine_model uEng (.*);
	task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
			n_mismatch++;
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// One access, then an idle edge so strobes never re-rise in one step
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		{regAddr, regWdata, regWr, regRd} = {a, d, w, !w};
		if (!w)
			expQ.push_back(d);
		@(posedge mclk);
		#1 {regWr, regRd} = 2'h0;
		@(posedge mclk);
		#1;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	always @(posedge mclk) begin
		if (rdPend)
			check("regRdata", regRdata, expQ.pop_front());
		rdPend = regRd;
	end
	initial begin
		repeat (30000) @(posedge mclk);
		n_mismatch++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(32'hF455));
		wt(10);
		rst = 1'b0;
		wt(3);
		for (int a = 0; a < 8; a++)
			acc(1'b0, 8'(a), a < 5 ? 8'h00 : 8'hAF);
		for (int a = 2; a < 8; a++) begin
			v = 8'($urandom);
			if (a == 4)
				dB = v;
			acc(1'b1, 8'(a), v);
			acc(1'b0, 8'(a), v);
		end
		acc(1'b1, 8'h01, 8'h2A);
		wt(3900);
		acc(1'b1, 8'h00, 8'hDC);
		wt(5);
		check("chipReady", chipReady, 1'b0);
		wt(12300);
		check("chipReady", chipReady, 1'b1);
		check("logDimming", logDimming, 1'b1);
		acc(1'b0, 8'h00, 8'hC0);
		acc(1'b0, 8'h09, 8'h01);
		acc(1'b0, 8'h0A, 8'h00);
		acc(1'b1, 8'h0B, 8'h05);
		acc(1'b0, 8'h0B, 8'h05);
		acc(1'b1, 8'h00, 8'hC2);
		wt(1700);
		check("runLevel", chanOut[2].runLevel, 1'b1);
		acc(1'b1, 8'h0B, 8'h09);
		acc(1'b0, 8'h0B, 8'h00);
		enPin = 1'b0;
		wt(10);
		check("chipReady", chipReady, 1'b0);
		acc(1'b0, 8'h00, 8'h82);
		enPin = 1'b1;
		acc(1'b1, 8'h01, 8'h13);
		wt(3900);
		acc(1'b0, 8'h09, 8'h00);
		check("loadOpen", chanOut[0].loadOpen, 1'b1);
		check("enabled", chanOut[1].enabled, 1'b0);
		check("direct", chanOut[2].direct, 1'b1);
		check("duty", chanOut[2].duty, dB);
		acc(1'b0, 8'h01, 8'h13);
		acc(1'b0, 8'h0C, 8'h00);
		tally_and_finish();
	end
endmodule // led_sequencer_control_regs_tb_top
